// File: hdl/csp_clk_chan.sv
// one generated clock: three-way source select followed by a power-of-two prescaler
// assumes source ticks are one-cycle strobes on clk_i; settings are held until a period boundary
`timescale 1ns/10ps
module csp_clk_chan
  import csp_pkg::*;
#(
  parameter int PRE_W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sources: bit 0 pll, bit 1 rc, bit 2 ext osc
  input wire logic [2:0] src_ticks_i,
  // settings
  input wire logic [1:0] sel_i,
  input wire logic [PRE_W-1:0] pre_i,
  input wire logic gate_i,
  // output
  output logic tick_o
);

  localparam int CNT_W = (1 << PRE_W) - 1;

  logic [1:0] act_sel_q;
  logic [PRE_W-1:0] act_pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] term;
  logic src;
  logic wrap;
  logic load;

  // source mux; the off code simply gives no ticks
  always_comb begin
    unique case (act_sel_q)
      SEL_PLL: src = src_ticks_i[0]; // R8
      SEL_RC: src = src_ticks_i[1]; // R8
      SEL_OSC: src = src_ticks_i[2]; // R8
      SEL_OFF: src = 1'b0;
    endcase
  end

  assign term = CNT_W'((32'd1 << act_pre_q) - 32'd1); // R10 R11
  assign wrap = src && (cnt_q == term);
  // new settings only at a period end or while idle at zero, so no short period
  assign load = wrap || ((cnt_q == '0) && !src); // R16

  // active settings follow the requested ones at safe points
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_sel_q <= SEL_RST;
      act_pre_q <= PRE_W'(PRE_RST);
    end else if (load) begin
      act_sel_q <= sel_i; // R8 R16
      act_pre_q <= pre_i; // R9 R16
    end
  end

  // prescaler counter over selected source ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || wrap) begin
      cnt_q <= '0;
    end else if (src) begin
      cnt_q <= cnt_q + CNT_W'(1); // R9
    end
  end

  // one output tick per full period; gating hides whole ticks only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap && !gate_i;
    end
  end

endmodule // csp_clk_chan

// File: hdl/csp_clock_source.sv
// clock source, pll and per-consumer prescaler block; every clock leaves as a tick on clk_i
// assumes crystal and user clock ticks arrive synchronous; srst_i is power reset, sys_rst_i system reset
`timescale 1ns/10ps
module csp_clock_source
  import csp_pkg::*;
#(
  parameter int NARROW_N = NUM_NARROW,
  parameter int WIDE_N = NUM_WIDE
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sys_rst_i,
  // external oscillator sources
  input wire logic xtal_tick_i,
  input wire logic user_clk_tick_i,
  // configuration, captured on cfg_wr_i
  input wire logic cfg_wr_i,
  input wire logic osc_user_sel_i,
  input wire logic pll_ref_sel_i,
  input wire logic pll_bypass_i,
  input wire logic [PLL_DIV_W-1:0] pll_fb_div_i,
  input wire logic [PLL_DIV_W-1:0] pll_ref_div_i,
  input wire logic [PLL_POST_W-1:0] pll_post_div_i,
  input wire logic [NARROW_N-1:0][1:0] narrow_sel_i,
  input wire logic [NARROW_N-1:0][NARROW_PRE_W-1:0] narrow_pre_i,
  input wire logic [WIDE_N-1:0][1:0] wide_sel_i,
  input wire logic [WIDE_N-1:0][WIDE_PRE_W-1:0] wide_pre_i,
  // processor state
  input wire logic sleep_i,
  // base clocks
  output logic ext_osc_clock_o,
  output logic rc_clock_o,
  output logic pll_output_o,
  // generated clocks
  output logic sys_clock_o,
  output logic converter_clock_o,
  output logic sync_serial_clock_o,
  output logic uart_clock_o,
  output logic timer0_clock_o,
  output logic timer1_clock_o,
  output logic [NUM_PWM-1:0] pwm_clocks_o,
  output logic rtc_clock_o,
  output logic watchdog_clock_o,
  output logic random_gen_clock_o
);

  localparam int RC_ACC_W = $clog2(CLK_FREQ_KHZ) + 1;
  localparam logic [RC_ACC_W-1:0] RC_STEP = RC_ACC_W'(RC_FREQ_KHZ);
  localparam logic [RC_ACC_W-1:0] RC_MOD = RC_ACC_W'(CLK_FREQ_KHZ);

  // configuration registers, power reset only
  logic osc_user_q;
  logic pll_ref_q;
  logic pll_bypass_q;
  logic [PLL_DIV_W-1:0] pll_m_q;
  logic [PLL_DIV_W-1:0] pll_n_q;
  logic [PLL_POST_W-1:0] pll_post_q;
  logic [NARROW_N-1:0][1:0] narrow_sel_q;
  logic [NARROW_N-1:0][NARROW_PRE_W-1:0] narrow_pre_q;
  logic [WIDE_N-1:0][1:0] wide_sel_q;
  logic [WIDE_N-1:0][WIDE_PRE_W-1:0] wide_pre_q;

  logic [RC_ACC_W-1:0] rc_acc_q;
  logic [RC_ACC_W-1:0] rc_sum;
  logic rc_wrap;
  logic pll_ref_tick;
  logic pll_tick;
  logic run_rst;
  logic [2:0] src_ticks;
  logic [NARROW_N-1:0] narrow_ticks;
  logic [WIDE_N-1:0] wide_ticks;
  logic [NARROW_N-1:0] narrow_gate;

  // counters and ticks restart on either reset; settings do not
  assign run_rst = srst_i || sys_rst_i;

  // settings ignore sys_rst_i so software clocks survive a system reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_user_q <= OSC_USER_RST; // R15
      pll_ref_q <= PLL_REF_RST; // R15
      pll_bypass_q <= PLL_BYPASS_RST; // R15
      pll_m_q <= PLL_M_RST;
      pll_n_q <= PLL_N_RST;
      pll_post_q <= PLL_POST_RST;
      narrow_sel_q <= {NARROW_N{SEL_RST}};
      narrow_pre_q <= {NARROW_N{NARROW_PRE_W'(PRE_RST)}};
      wide_sel_q <= {WIDE_N{SEL_RST}};
      wide_pre_q <= {WIDE_N{WIDE_PRE_W'(PRE_RST)}};
    end else if (cfg_wr_i) begin
      osc_user_q <= osc_user_sel_i;
      pll_ref_q <= pll_ref_sel_i;
      pll_bypass_q <= pll_bypass_i;
      pll_m_q <= pll_fb_div_i;
      pll_n_q <= pll_ref_div_i;
      pll_post_q <= pll_post_div_i;
      narrow_sel_q <= narrow_sel_i;
      narrow_pre_q <= narrow_pre_i;
      wide_sel_q <= wide_sel_i;
      wide_pre_q <= wide_pre_i;
    end
  end

  // external oscillator clock: crystal or user clock
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      ext_osc_clock_o <= 1'b0;
    end else begin
      ext_osc_clock_o <= osc_user_q ? user_clk_tick_i : xtal_tick_i; // R1
    end
  end

  // rc oscillator: fractional divider of clk_i, average rate exact, jitter one cycle
  assign rc_sum = rc_acc_q + RC_STEP;
  assign rc_wrap = rc_sum >= RC_MOD;

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      rc_acc_q <= '0;
      rc_clock_o <= 1'b0;
    end else begin
      rc_acc_q <= rc_wrap ? rc_sum - RC_MOD : rc_sum; // R2
      rc_clock_o <= rc_wrap; // R2
    end
  end

  // pll reference mux
  assign pll_ref_tick = (pll_ref_q == PLL_REF_RC) ? rc_clock_o : ext_osc_clock_o; // R3

  csp_pll u_pll (
    .clk_i(clk_i),
    .rst_i(run_rst),
    .ref_tick_i(pll_ref_tick),
    .bypass_i(pll_bypass_q),
    .fb_div_i(pll_m_q),
    .ref_div_i(pll_n_q),
    .post_div_i(pll_post_q),
    .out_tick_o(pll_tick)
  );

  assign pll_output_o = pll_tick;
  assign src_ticks = {ext_osc_clock_o, rc_clock_o, pll_tick};

  // sleep stops the converter clock only in the narrow group
  always_comb begin
    narrow_gate = '0;
    narrow_gate[CH_CONV] = sleep_i; // R13
  end

  // four-ratio channels
  for (genvar gi = 0; gi < NARROW_N; gi++) begin : g_narrow
    csp_clk_chan #(
      .PRE_W(NARROW_PRE_W)
    ) u_chan (
      .clk_i(clk_i),
      .rst_i(run_rst),
      .src_ticks_i(src_ticks),
      .sel_i(narrow_sel_q[gi]),
      .pre_i(narrow_pre_q[gi]),
      .gate_i(narrow_gate[gi]),
      .tick_o(narrow_ticks[gi])
    ); // R10
  end

  // eight-ratio channels
  for (genvar gj = 0; gj < WIDE_N; gj++) begin : g_wide
    csp_clk_chan #(
      .PRE_W(WIDE_PRE_W)
    ) u_chan (
      .clk_i(clk_i),
      .rst_i(run_rst),
      .src_ticks_i(src_ticks),
      .sel_i(wide_sel_q[gj]),
      .pre_i(wide_pre_q[gj]),
      .gate_i(1'b0),
      .tick_o(wide_ticks[gj])
    ); // R11
  end

  // named outputs from the channel banks
  assign sys_clock_o = narrow_ticks[CH_SYS];
  assign converter_clock_o = narrow_ticks[CH_CONV];
  assign sync_serial_clock_o = narrow_ticks[CH_SSP];
  assign uart_clock_o = narrow_ticks[CH_UART];
  assign timer0_clock_o = wide_ticks[CH_TIM0];
  assign timer1_clock_o = wide_ticks[CH_TIM1];
  assign pwm_clocks_o = wide_ticks[CH_PWM0 +: NUM_PWM];
  assign rtc_clock_o = wide_ticks[CH_RTC];
  assign watchdog_clock_o = wide_ticks[CH_WDOG];

  // random generator clock: pll only, registered so the sleep gate cannot glitch it
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      random_gen_clock_o <= 1'b0;
    end else begin
      random_gen_clock_o <= pll_tick && !sleep_i; // R12 R13
    end
  end

endmodule // csp_clock_source

// File: hdl/csp_pkg.sv
// constants shared by the clock source, pll and prescaler channel logic
// assumes every source clock reaches the block as a one-cycle tick synchronous to clk_i
// Function
// R1 - ext_osc_clock comes from crystal ticks or a user clock, software selectable
// R2 - internal rc clock is made on chip at 8 MHz, no outside parts
// R3 - pll reference is chosen between ext_osc_clock and rc clock by software
// R4 - pll output rate is input rate times feedback divider over reference and post dividers
// R5 - feedback divider is a 6-bit unsigned binary value
// R6 - reference divider is a 6-bit unsigned binary value
// R7 - pll_post_div is 2 bits: high bit factor four, low bit factor two
// R8 - every generated clock selects pll, rc or ext_osc_clock on its own; random_gen_clock has no selector here, pll only
// R9 - every generated clock has its own prescaler set on its own; random_gen_clock has no prescaler here
// R10 - system, converter, sync serial and uart clocks divide by 1, 2, 4 or 8
// R11 - timers, pwm, rtc and watchdog clocks divide by 1 up to 128
// R12 - random_gen_clock is the pll output only, no selector or prescaler
// R13 - converter and random generator clocks stop while the processor sleeps
// R14 - pll bypass passes its input clock straight through
// R15 - clock configuration survives system reset, cleared only by power reset
// R16 - select and prescale changes never shorten or glitch a generated clock
package csp_pkg;

  // rates used to build the rc oscillator from clk_i
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int RC_FREQ_KHZ = 8000;

  // source select encoding of each generated clock
  localparam logic [1:0] SEL_PLL = 2'h0;
  localparam logic [1:0] SEL_RC = 2'h1;
  localparam logic [1:0] SEL_OSC = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;

  // pll reference select encoding
  localparam logic PLL_REF_OSC = 1'h0;
  localparam logic PLL_REF_RC = 1'h1;

  // field widths
  localparam int PLL_DIV_W = 6;
  localparam int PLL_POST_W = 2;
  localparam int NARROW_PRE_W = 2;
  localparam int WIDE_PRE_W = 3;

  // channel groups: narrow = sys, converter, sync serial, uart
  localparam int NUM_NARROW = 4;
  localparam int NUM_WIDE = 12;
  localparam int CH_SYS = 0;
  localparam int CH_CONV = 1;
  localparam int CH_SSP = 2;
  localparam int CH_UART = 3;
  // wide group: timer0, timer1, pwm0..7, rtc, watchdog
  localparam int CH_TIM0 = 0;
  localparam int CH_TIM1 = 1;
  localparam int CH_PWM0 = 2;
  localparam int NUM_PWM = 8;
  localparam int CH_RTC = 10;
  localparam int CH_WDOG = 11;

  // power reset values of the configuration
  localparam logic [1:0] SEL_RST = SEL_RC;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic PLL_REF_RST = PLL_REF_RC;
  localparam logic PLL_BYPASS_RST = 1'h1;
  localparam logic [5:0] PLL_M_RST = 6'h01;
  localparam logic [5:0] PLL_N_RST = 6'h01;
  localparam logic [1:0] PLL_POST_RST = 2'h0;
  localparam logic OSC_USER_RST = 1'h0;

endpackage : csp_pkg

// File: hdl/csp_pll.sv
// digital rate multiplier standing in for the pll: input ticks in, output ticks out
// assumes the output rate stays at or below clk_i; a faster request saturates at one tick per cycle
`timescale 1ns/10ps
module csp_pll
  import csp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reference and settings
  input wire logic ref_tick_i,
  input wire logic bypass_i,
  input wire logic [PLL_DIV_W-1:0] fb_div_i,
  input wire logic [PLL_DIV_W-1:0] ref_div_i,
  input wire logic [PLL_POST_W-1:0] post_div_i,
  // output
  output logic out_tick_o
);

  localparam int ACC_W = PLL_DIV_W + 4;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_add;
  logic [ACC_W-1:0] thresh;
  logic emit;

  // denominator: reference divider shifted left by the two-bit post divider field
  assign thresh = ACC_W'(ref_div_i) << post_div_i; // R6 R7
  assign acc_add = ref_tick_i ? ACC_W'(fb_div_i) : '0; // R5
  // a zero divider stops the output instead of dividing by zero
  assign emit = (thresh != '0) && (fb_div_i != '0) && ((acc_q + acc_add) >= thresh);

  // accumulate m per input tick, give back n*od per output tick
  always_ff @(posedge clk_i) begin
    if (rst_i || bypass_i) begin
      acc_q <= '0;
    end else if (emit) begin
      acc_q <= acc_q + acc_add - thresh; // R4
    end else begin
      acc_q <= acc_q + acc_add; // R4
    end
  end

  // bypass hands the reference through one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_tick_o <= 1'b0;
    end else if (bypass_i) begin
      out_tick_o <= ref_tick_i; // R14
    end else begin
      out_tick_o <= emit; // R4
    end
  end

endmodule // csp_pll

// File: tb/csp_clock_source_checker.sv
// checker: tick relations of csp_clock_source
// assumes bound to the top, configuration moves only on cfg_wr_i
`timescale 1ns/10ps
module csp_clock_source_checker
  import csp_pkg::*;
#(
  parameter int NARROW_N = NUM_NARROW,
  parameter int WIDE_N = NUM_WIDE
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sys_rst_i,
  // inputs
  input wire logic xtal_tick_i,
  input wire logic user_clk_tick_i,
  input wire logic cfg_wr_i,
  input wire logic osc_user_sel_i,
  input wire logic pll_ref_sel_i,
  input wire logic pll_bypass_i,
  input wire logic [NARROW_N-1:0][1:0] narrow_sel_i,
  input wire logic [NARROW_N-1:0][NARROW_PRE_W-1:0] narrow_pre_i,
  input wire logic sleep_i,
  // outputs
  input wire logic ext_osc_clock_o,
  input wire logic rc_clock_o,
  input wire logic pll_output_o,
  input wire logic sys_clock_o,
  input wire logic converter_clock_o,
  input wire logic random_gen_clock_o
);
  logic osc_q, ref_q, byp_q, steady;
  logic [1:0] ssel_q, spre_q;
  logic [8:0] quiet_q, gap_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i || sys_rst_i);
  // shadow configuration; system reset must not touch it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_q <= OSC_USER_RST;
      ref_q <= PLL_REF_RST;
      byp_q <= PLL_BYPASS_RST;
      ssel_q <= SEL_RST;
      spre_q <= PRE_RST[1:0];
    end else if (cfg_wr_i) begin
      osc_q <= osc_user_sel_i;
      ref_q <= pll_ref_sel_i;
      byp_q <= pll_bypass_i;
      ssel_q <= narrow_sel_i[CH_SYS];
      spre_q <= narrow_pre_i[CH_SYS];
    end
  end
  // quiet time lets a channel finish its old period before it is judged
  always_ff @(posedge clk_i) begin
    if (srst_i || sys_rst_i || cfg_wr_i) quiet_q <= 9'h000;
    else if (quiet_q != 9'h1FF) quiet_q <= quiet_q + 9'h001;
  end
  // rc ticks seen since the last sys tick
  always_ff @(posedge clk_i) begin
    if (srst_i || sys_rst_i) gap_q <= 9'h000;
    else if (sys_clock_o) gap_q <= {8'h00, rc_clock_o};
    else gap_q <= gap_q + {8'h00, rc_clock_o};
  end
  assign steady = quiet_q == 9'h1FF;
  sequence s_live;
    !$past(srst_i) && !$past(sys_rst_i) && !$past(cfg_wr_i);
  endsequence
  sequence s_rc_gap;
    (!rc_clock_o)[*7] ##1 (!rc_clock_o)[*7] ##[1:2] rc_clock_o;
  endsequence
  chk_osc_follow: assert property (s_live |-> ext_osc_clock_o == $past(osc_q ? user_clk_tick_i : xtal_tick_i))
    else $error("ext osc tick does not follow its source");
  chk_rc_rate: assert property (rc_clock_o |=> s_rc_gap)
    else $error("rc tick spacing wrong");
  chk_pll_bypass: assert property (s_live ##0 byp_q |-> pll_output_o == $past(ref_q ? rc_clock_o : ext_osc_clock_o))
    else $error("bypass output differs from reference");
  chk_rng_gate: assert property (s_live |-> random_gen_clock_o == $past(pll_output_o && !sleep_i))
    else $error("random gen tick differs from pll tick");
  chk_conv_sleep: assert property (sleep_i && $past(sleep_i) |-> !converter_clock_o)
    else $error("converter tick during sleep");
  chk_sys_ratio: assert property (steady && ssel_q == SEL_RC && sys_clock_o |-> gap_q == (9'h001 << spre_q))
    else $error("sys tick ratio wrong");
  chk_sys_osc: assert property (steady && ssel_q == SEL_OSC && spre_q == 2'h0 |-> sys_clock_o == $past(ext_osc_clock_o))
    else $error("sys tick not from ext osc");
  chk_sys_pll: assert property (steady && ssel_q == SEL_PLL && spre_q == 2'h0 |-> sys_clock_o == $past(pll_output_o))
    else $error("sys tick not from pll");
  chk_sys_off: assert property (steady && ssel_q == SEL_OFF |-> !sys_clock_o)
    else $error("sys tick while its source is off");
endmodule // csp_clock_source_checker

// File: tb/csp_clock_source_tb_top.sv
// bench: counts every clock over 2000-cycle windows, which hold whole source periods
// assumes csp_osc_model gives crystal ticks every 10 cycles, user ticks every 5
`timescale 1ns/10ps
module csp_clock_source_tb_top
  import csp_pkg::*;
();
  typedef struct {
    logic osc, rsel, byp;
    logic [5:0] m, n;
    logic [1:0] pd, ss, sp, ts;
    logic [2:0] tp;
    int ep, es, et;
  } csp_row_t;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sys_rst_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic sleep_i = 1'b0;
  logic clr = 1'b0;
  logic xtal_tick_i, user_clk_tick_i, osc_user_sel_i, pll_ref_sel_i, pll_bypass_i;
  logic [5:0] pll_fb_div_i, pll_ref_div_i;
  logic [1:0] pll_post_div_i;
  logic [NUM_NARROW-1:0][1:0] narrow_sel_i, narrow_pre_i;
  logic [NUM_WIDE-1:0][1:0] wide_sel_i;
  logic [NUM_WIDE-1:0][2:0] wide_pre_i;
  logic ext_osc_clock_o, rc_clock_o, pll_output_o, sys_clock_o, converter_clock_o, sync_serial_clock_o;
  logic uart_clock_o, timer0_clock_o, timer1_clock_o, rtc_clock_o, watchdog_clock_o, random_gen_clock_o;
  localparam int NM = 20;
  localparam int XTAL_DIV = 10;
  localparam int USER_DIV = 5;
  logic [7:0] pwm_clocks_o;
  logic [NM-1:0] mon;
  int cnt [NM];
  int fails = 0;
  int n_tests = 0;
  string nm [NM] = '{"pll", "rng", "sys", "conv", "ssp", "uart", "tim0", "tim1", "pwm0", "pwm1", "pwm2", "pwm3",
    "pwm4", "pwm5", "pwm6", "pwm7", "rtc", "wdog", "rc", "osc"};
  // osc, ref, bypass, m, n, post, sys sel/pre, wide sel/pre, expected pll, sys, wide counts
  csp_row_t rows [7] = '{
    '{1'b0, PLL_REF_RC, 1'b1, 6'h01, 6'h01, 2'h0, SEL_RC, 2'h0, SEL_OSC, 3'h0, 128, 128, 200},
    '{1'b0, PLL_REF_RC, 1'b0, 6'h20, 6'h20, 2'h1, SEL_RC, 2'h3, SEL_RC, 3'h7, 64, 16, 1},
    '{1'b0, PLL_REF_OSC, 1'b0, 6'h01, 6'h01, 2'h3, SEL_OSC, 2'h0, SEL_PLL, 3'h0, 25, 200, 25},
    '{1'b0, PLL_REF_RC, 1'b0, 6'h05, 6'h0A, 2'h2, SEL_PLL, 2'h0, SEL_PLL, 3'h4, 16, 16, 1},
    '{1'b1, PLL_REF_OSC, 1'b1, 6'h01, 6'h01, 2'h0, SEL_RC, 2'h2, SEL_RC, 3'h5, 400, 32, 4},
    '{1'b0, PLL_REF_RC, 1'b0, 6'h00, 6'h01, 2'h0, SEL_OFF, 2'h0, SEL_PLL, 3'h0, 0, 0, 0},
    '{1'b1, PLL_REF_OSC, 1'b0, 6'h03, 6'h06, 2'h0, SEL_PLL, 2'h1, SEL_OSC, 3'h4, 200, 100, 25}};
  csp_clock_source i_dut (.*);
  csp_osc_model #(.XTAL_DIV(XTAL_DIV), .USER_DIV(USER_DIV)) i_osc (.clk_i(clk_i), .xtal_tick_o(xtal_tick_i),
    .user_tick_o(user_clk_tick_i));
  assign mon = {ext_osc_clock_o, rc_clock_o, watchdog_clock_o, rtc_clock_o, pwm_clocks_o, timer1_clock_o,
    timer0_clock_o, uart_clock_o, sync_serial_clock_o, converter_clock_o, sys_clock_o, random_gen_clock_o,
    pll_output_o};
  initial forever #4 clk_i = ~clk_i;
  // tick counters; anything but a clean low counts, so an unknown output cannot pass a zero count
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NM; i++) cnt[i] <= clr ? 0 : cnt[i] + ((mon[i] === 1'b0) ? 0 : 1);
  end
  task automatic end_sim();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic set(input csp_row_t r);
    osc_user_sel_i <= r.osc;
    pll_ref_sel_i <= r.rsel;
    pll_bypass_i <= r.byp;
    pll_fb_div_i <= r.m;
    pll_ref_div_i <= r.n;
    pll_post_div_i <= r.pd;
    narrow_sel_i <= {NUM_NARROW{r.ss}};
    narrow_pre_i <= {NUM_NARROW{r.sp}};
    wide_sel_i <= {NUM_WIDE{r.ts}};
    wide_pre_i <= {NUM_WIDE{r.tp}};
  endtask
  // settle long enough for a 1/128 channel to reach its period boundary
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // 2000-cycle window holds whole periods of every source, so every count is exact
  task automatic meas(input int ep, input int es, input int et, input int eo);
    int e [NM];
    @(posedge clk_i) clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
    // expectations read sleep_i only after it has settled
    for (int i = 0; i < NM; i++) begin
      e[i] = (i < 2) ? ep : (i < 6) ? es : (i < 18) ? et : (i == 18) ? 2000 * RC_FREQ_KHZ / CLK_FREQ_KHZ : eo;
    end
    if (sleep_i) begin
      e[1] = 0;
      e[3] = 0;
    end
    wait_cyc(2000);
    #1;
    for (int i = 0; i < NM; i++) begin
      n_tests++;
      if (cnt[i] != e[i]) begin
        fails++;
        $display("[FAIL] %s ticks exp %0d got %0d", nm[i], e[i], cnt[i]);
      end
    end
  endtask
  initial begin
    set(rows[0]);
    wait_cyc(8);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_i) cfg_wr_i <= 1'b1;
      set(rows[i]);
      @(posedge clk_i) cfg_wr_i <= 1'b0;
      wait_cyc(2200);
      meas(rows[i].ep, rows[i].es, rows[i].et, rows[i].osc ? 2000 / USER_DIV : 2000 / XTAL_DIV);
    end
    // system reset keeps the last setup, power reset restores defaults
    @(posedge clk_i) sys_rst_i <= 1'b1;
    wait_cyc(4);
    sys_rst_i <= 1'b0;
    wait_cyc(300);
    meas(200, 100, 25, 2000 / USER_DIV);
    @(posedge clk_i) srst_i <= 1'b1;
    wait_cyc(4);
    srst_i <= 1'b0;
    wait_cyc(300);
    meas(128, 128, 128, 2000 / XTAL_DIV);
    @(posedge clk_i) sleep_i <= 1'b1;
    meas(128, 128, 128, 2000 / XTAL_DIV);
    end_sim();
  end
  initial begin
    wait_cyc(60000);
    fails++;
    end_sim();
  end
endmodule // csp_clock_source_tb_top
bind csp_clock_source csp_clock_source_checker #(.NARROW_N(NARROW_N), .WIDE_N(WIDE_N)) i_chk (.*);

// File: tb/csp_osc_model.sv
// crystal and user clock ticks, both free running on clk_i
`timescale 1ns/10ps
module csp_osc_model #(
  parameter int XTAL_DIV = 10,
  parameter int USER_DIV = 5
) (
  input wire logic clk_i,
  output logic xtal_tick_o,
  output logic user_tick_o
);
  int xc = 0;
  int uc = 0;
  // oscillators ignore reset, as the real parts would
  always_ff @(posedge clk_i) begin
    xc <= (xc == XTAL_DIV - 1) ? 0 : xc + 1;
    uc <= (uc == USER_DIV - 1) ? 0 : uc + 1;
  end
  assign xtal_tick_o = xc == 0;
  assign user_tick_o = uc == 0;
endmodule // csp_osc_model
